// file: design/sbtc_timer.sv
// sixteen-bit timer/counter with wishbone register slave
// Contract
// - counter advances only while run enable bit 0 is set
// - source bit 1: zero counts instruction cycles, one counts external rising edges
// - three modes: timer, synchronous counter, asynchronous counter
// - prescale field bits 5-4 divides by 1, 2, 4 or 8
// - oscillator enable bit 3 starts or stops the crystal oscillator
// - enabled oscillator keeps running in every power-managed mode
// - read-only bit 6 shows system clock taken from this oscillator
// - wide access bit 7 maps high-byte address to a holding buffer
// - with wide access bit 7 set, a low-byte read copies live high byte into holding buffer
// - buffered high write loads buffer; low write moves it into live high
// - low-byte write clears prescaler; high-byte write does not
// - both oscillator pins are always inputs; both read zero while run enable bit 0 is set
// - compare special event trigger clears the count, except in asynchronous counter mode
// - count wraps FFFFh to 0000h and sets sticky overflow flag
// - trigger clear never sets the overflow flag
// - a low-byte count write beats a coincident trigger clear
//
// The Wishbone register port and the address map were decided locally.
`timescale 1ns/1ps
`default_nettype none
module sbtc_timer
    import sbtc_pkg::*;
(
    input wire logic clk_i, // 125 MHz system clock
    input wire logic rst_i, // synchronous reset, active high
    input wire logic wb_cyc_i, // wishbone cycle
    input wire logic wb_stb_i, // wishbone strobe
    input wire logic wb_we_i, // wishbone write enable
    input wire logic [4:0] wb_adr_i, // wishbone byte address
    input wire logic [3:0] wb_sel_i, // wishbone byte selects
    input wire logic [31:0] wb_dat_i, // wishbone write data
    output logic [31:0] wb_dat_o, // wishbone read data
    output logic wb_ack_o, // wishbone acknowledge
    output logic irq_o, // level interrupt
    input wire logic ext_clock_pin_i, // external clock pin level
    input wire logic osc_clock_i, // oscillator output level
    input wire logic special_event_i, // compare special event trigger pulse
    input wire logic sysclk_is_osc_i, // system clock source is this oscillator
    input wire logic power_managed_i, // device in a power-managed mode
    output logic osc_run_o, // oscillator amplifier enabled
    output logic osc_in_pin_oe_o, // osc_in_pin output enable
    output logic osc_out_pin_oe_o, // osc_out_pin output enable
    output logic pins_read_zero_o // port reads of both pins return zero
);
    typedef struct packed {
        logic [7:0] ctrl;
        logic [15:0] count;
        logic [7:0] high_buf;
        logic [2:0] presc;
        logic [1:0] icyc;
        logic ext_q;
        logic ovf;
        logic ovf_mask;
        logic ack;
        logic [31:0] rdata;
    } sbtc_state_t;

    sbtc_state_t st_r;
    sbtc_state_t st_nxt;
    sbtc_wb_req_t req;
    sbtc_mode_t mode;
    logic ext_raw;
    logic ext_sync;
    logic ext_sel;
    logic tick;
    logic src_edge;
    logic presc_hit;
    logic bus_go;
    logic wr_low;
    logic wr_high;
    logic rd_low;
    logic [2:0] presc_lim;
    logic [7:0] ctrl_view;

    // external source: crystal oscillator when enabled, otherwise the pin
    assign ext_raw = st_r.ctrl[SBTC_B_OSCEN] ? osc_clock_i : ext_clock_pin_i;

    sbtc_sync3 u_sync (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .d_i(ext_raw),
        .q_o(ext_sync)
    );

    // mode from source and sync bits
    always_comb begin
        if (!st_r.ctrl[SBTC_B_CSEL]) begin
            mode = SBTC_M_TIMER;
        end else if (st_r.ctrl[SBTC_B_SYNCB]) begin
            mode = SBTC_M_ASYNC;
        end else begin
            mode = SBTC_M_SYNC;
        end
    end

    // bypass path still sees the filtered level; the only safe edge detector
    // in a single-clock design, so async mode counts the same edge as sync mode
    assign ext_sel = (mode == SBTC_M_ASYNC) ? ext_sync : st_r.ext_q;

    // source tick: instruction cycle or external rising edge
    // one count per synchronised rising edge
    assign src_edge = ext_sync & ~st_r.ext_q;
    always_comb begin
        case (mode)
            SBTC_M_TIMER: tick = (st_r.icyc == SBTC_ICYC_LAST);
            SBTC_M_SYNC: tick = src_edge;
            SBTC_M_ASYNC: tick = ext_sel & ~st_r.ext_q;
            default: tick = 1'b0;
        endcase
    end

    // prescale limit 0, 1, 3, 7
    assign presc_lim = 3'((4'h1 << st_r.ctrl[SBTC_B_PS_LO +: 2]) - 4'h1);
    assign presc_hit = tick && (st_r.presc == presc_lim);

    // bus decode
    assign req = '{cyc: wb_cyc_i, stb: wb_stb_i, we: wb_we_i, adr: wb_adr_i, sel: wb_sel_i, dat: wb_dat_i};
    assign bus_go = req.cyc && req.stb && !st_r.ack;
    assign wr_low = bus_go && req.we && req.sel[0] && (req.adr == 5'(SBTC_OFF_LOW));
    assign wr_high = bus_go && req.we && req.sel[0] && (req.adr == 5'(SBTC_OFF_HIGH));
    assign rd_low = bus_go && !req.we && (req.adr == 5'(SBTC_OFF_LOW));

    // status bit is live, not stored
    always_comb begin
        ctrl_view = st_r.ctrl;
        ctrl_view[SBTC_B_SYSOSC] = sysclk_is_osc_i;
    end

    // next state
    always_comb begin
        st_nxt = st_r;
        st_nxt.ack = bus_go;
        st_nxt.ext_q = ext_sync;
        st_nxt.icyc = 2'(st_r.icyc + 2'h1);
        if (st_r.ctrl[SBTC_B_RUN] && tick) begin
            st_nxt.presc = presc_hit ? 3'h0 : 3'(st_r.presc + 3'h1);
            if (presc_hit) begin
                st_nxt.count = 16'(st_r.count + 16'h0001);
                if (st_r.count == 16'hFFFF) begin
                    st_nxt.ovf = 1'b1;
                end
            end
        end
        // trigger clears count; async mode ignores it by design
        if (special_event_i && mode != SBTC_M_ASYNC) begin
            st_nxt.count = SBTC_COUNT_RST;
        end
        // register reads
        st_nxt.rdata = 32'h0000_0000;
        if (bus_go && !req.we) begin
            case (req.adr)
                5'(SBTC_OFF_CTRL): st_nxt.rdata = {24'h000000, ctrl_view};
                5'(SBTC_OFF_LOW): st_nxt.rdata = {24'h000000, st_r.count[7:0]};
                // high address reads buffer when wide access set
                5'(SBTC_OFF_HIGH): st_nxt.rdata = {24'h000000,
                    st_r.ctrl[SBTC_B_WIDE] ? st_r.high_buf : st_r.count[15:8]};
                5'(SBTC_OFF_STAT): begin
                    st_nxt.rdata = {31'h0000_0000, st_r.ovf};
                    // read clears, but a wrap in this cycle wins
                    st_nxt.ovf = (st_r.ctrl[SBTC_B_RUN] && presc_hit && st_r.count == 16'hFFFF);
                end
                5'(SBTC_OFF_MASK): st_nxt.rdata = {31'h0000_0000, st_r.ovf_mask};
                default: st_nxt.rdata = 32'h0000_0000;
            endcase
        end
        // low read latches live high byte
        if (rd_low && st_r.ctrl[SBTC_B_WIDE]) begin
            st_nxt.high_buf = st_r.count[15:8];
        end
        // control and mask writes
        if (bus_go && req.we && req.sel[0]) begin
            if (req.adr == 5'(SBTC_OFF_CTRL)) begin
                st_nxt.ctrl = req.dat[7:0];
                st_nxt.ctrl[SBTC_B_SYSOSC] = 1'b0;
            end
            if (req.adr == SBTC_OFF_MASK) begin
                st_nxt.ovf_mask = req.dat[0];
            end
        end
        // buffered high write only loads buffer
        if (wr_high) begin
            if (st_r.ctrl[SBTC_B_WIDE]) begin
                st_nxt.high_buf = req.dat[7:0];
            end else begin
                st_nxt.count[15:8] = req.dat[7:0];
            end
        end
        // write placed last so it overrides trigger clear
        if (wr_low) begin
            st_nxt.count[7:0] = req.dat[7:0];
            if (st_r.ctrl[SBTC_B_WIDE]) begin
                st_nxt.count[15:8] = st_r.high_buf;
            end else if (!wr_high) begin
                st_nxt.count[15:8] = special_event_i && mode != SBTC_M_ASYNC ? st_r.count[15:8]
                    : st_nxt.count[15:8];
            end
            // prescaler cleared on low write only
            st_nxt.presc = 3'h0;
        end
    end

    // state register
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            st_r <= '0;
            st_r.ctrl <= SBTC_CTRL_RST;
            st_r.count <= SBTC_COUNT_RST;
        end else begin
            st_r <= st_nxt;
        end
    end

    // outputs
    assign wb_ack_o = st_r.ack;
    assign wb_dat_o = st_r.rdata;
    assign irq_o = st_r.ovf & st_r.ovf_mask;
    // power-managed state does not gate it
    assign osc_run_o = st_r.ctrl[SBTC_B_OSCEN] | (st_r.ctrl[SBTC_B_OSCEN] & power_managed_i);
    // pins always inputs; reads return zero while run bit set
    assign osc_in_pin_oe_o = 1'b0;
    assign osc_out_pin_oe_o = 1'b0;
    assign pins_read_zero_o = st_r.ctrl[SBTC_B_RUN];
endmodule : sbtc_timer
`default_nettype wire

// file: design/sbtc_pkg.sv
// package for the sixteen-bit timer/counter: offsets, fields, reset values, types
package sbtc_pkg;
    // register word offsets (byte addresses)
    localparam logic [3:0] SBTC_OFF_CTRL = 4'h0;
    localparam logic [3:0] SBTC_OFF_LOW = 4'h4;
    localparam logic [3:0] SBTC_OFF_HIGH = 4'h8;
    localparam logic [3:0] SBTC_OFF_STAT = 4'hC;
    localparam logic [4:0] SBTC_OFF_MASK = 5'h10;
    // control field positions
    localparam int SBTC_B_RUN = 0;
    localparam int SBTC_B_CSEL = 1;
    localparam int SBTC_B_SYNCB = 2;
    localparam int SBTC_B_OSCEN = 3;
    localparam int SBTC_B_PS_LO = 4;
    localparam int SBTC_B_SYSOSC = 6;
    localparam int SBTC_B_WIDE = 7;
    // reset values
    localparam logic [7:0] SBTC_CTRL_RST = 8'h00;
    localparam logic [15:0] SBTC_COUNT_RST = 16'h0000;
    // instruction cycle is system clock divided by four
    localparam logic [1:0] SBTC_ICYC_LAST = 2'h3;

    typedef enum logic [1:0] {
        SBTC_M_TIMER,
        SBTC_M_SYNC,
        SBTC_M_ASYNC
    } sbtc_mode_t;

    // classic wishbone request
    typedef struct packed {
        logic cyc;
        logic stb;
        logic we;
        logic [4:0] adr;
        logic [3:0] sel;
        logic [31:0] dat;
    } sbtc_wb_req_t;
endpackage : sbtc_pkg

// file: design/sbtc_sync3.sv
// three-stage input synchroniser with agreement filter
`timescale 1ns/1ps
`default_nettype none
module sbtc_sync3 (
    input wire logic clk_i, // system clock
    input wire logic rst_i, // synchronous reset
    input wire logic d_i, // asynchronous input
    output logic q_o // filtered synchronous level
);
    logic s1_r;
    logic s2_r;
    logic s3_r;
    logic q_r;

    // first stage feeds only the second; change taken when stages two and three agree
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            s1_r <= 1'b0;
            s2_r <= 1'b0;
            s3_r <= 1'b0;
            q_r <= 1'b0;
        end else begin
            s1_r <= d_i;
            s2_r <= s1_r;
            s3_r <= s2_r;
            if (s2_r == s3_r) begin
                q_r <= s3_r;
            end
        end
    end
    assign q_o = q_r;
endmodule : sbtc_sync3
`default_nettype wire

// file: verif/sbtc_timer_assertions.sv
// bound checker for the timer register slave
`timescale 1ns/1ps
`default_nettype none
module sbtc_timer_assertions (
    input wire logic clk_i, // clock
    input wire logic rst_i, // reset
    input wire logic wb_cyc_i, // cyc
    input wire logic wb_stb_i, // stb
    input wire logic wb_we_i, // we
    input wire logic [4:0] wb_adr_i, // adr
    input wire logic [3:0] wb_sel_i, // sel
    input wire logic [31:0] wb_dat_i, // wdata
    input wire logic [31:0] wb_dat_o, // rdata
    input wire logic wb_ack_o, // ack
    input wire logic irq_o, // irq
    input wire logic sysclk_is_osc_i, // source
    input wire logic osc_run_o, // osc on
    input wire logic osc_in_pin_oe_o, // oe
    input wire logic osc_out_pin_oe_o, // oe
    input wire logic pins_read_zero_o // zero
);
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (rst_i);
    // completed control and mask writes
    logic cw;
    logic mw;
    assign cw = wb_ack_o & wb_we_i & wb_sel_i[0] & (wb_adr_i == 5'h00);
    assign mw = wb_ack_o & wb_we_i & wb_sel_i[0] & (wb_adr_i == 5'h10);
    AST_ACK_ONE: assert property (wb_cyc_i & wb_stb_i & !wb_ack_o |=> wb_ack_o)
        else $error("ack late");
    AST_ACK_PULSE: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("ack long");
    AST_RUN_PINS: assert property (cw |=> pins_read_zero_o == $past(wb_dat_i[0]))
        else $error("pin zero wrong");
    AST_OSC_RUN: assert property (cw |=> osc_run_o == $past(wb_dat_i[3]))
        else $error("osc enable wrong");
    AST_OSC_KEEP: assert property (!cw |-> $stable(osc_run_o))
        else $error("osc changed");
    AST_PIN_OE: assert property (!osc_in_pin_oe_o && !osc_out_pin_oe_o)
        else $error("pin driven");
    AST_SYSOSC: assert property (wb_ack_o & !wb_we_i & (wb_adr_i == 5'h00)
        |-> wb_dat_o[6] == $past(sysclk_is_osc_i)) else $error("clock status wrong");
    AST_MASK: assert property (mw & !wb_dat_i[0] |=> ##1 !irq_o)
        else $error("masked irq high");
    cover property (cw & wb_dat_i[0]);
    cover property ($rose(irq_o));
    cover property (wb_ack_o & (wb_adr_i == 5'h0C) & wb_dat_o[0]);
endmodule : sbtc_timer_assertions
bind sbtc_timer sbtc_timer_assertions i_chk (.*);
`default_nettype wire

// file: verif/sbtc_clk_src.sv
// far-side clock source: pulse bursts on the pin or the crystal line
`timescale 1ns/1ps
`default_nettype none
module sbtc_clk_src (
    input wire logic clk_i, // bench clock
    input wire logic use_osc_i, // pulse crystal line
    input wire logic go_i, // start burst
    output logic ext_o, // pin level
    output logic osc_o, // crystal level
    output logic done_o // burst over
);
    int k;
    // lines stand low between bursts; five pulses, eight cycles high then eight low
    initial begin
        ext_o = 1'b0;
        osc_o = 1'b0;
        done_o = 1'b1;
        forever begin
            @(posedge clk_i);
            if (go_i) begin
                done_o <= 1'b0;
                for (k = 0; k < 10; k++) begin
                    ext_o <= !use_osc_i && !k[0];
                    osc_o <= use_osc_i && !k[0];
                    repeat (8) @(posedge clk_i);
                end
                done_o <= 1'b1;
            end
        end
    end
endmodule : sbtc_clk_src
`default_nettype wire

// file: verif/tb_top.sv
// self-checking bench for the sixteen-bit timer/counter
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    logic clk_i = 0, rst_i = 1, wb_cyc_i = 0, wb_stb_i = 0, wb_we_i = 0, wb_ack_o, irq_o;
    logic [4:0] wb_adr_i = 0;
    logic [3:0] wb_sel_i = 0;
    logic [31:0] wb_dat_i = 0, wb_dat_o, q;
    logic special_event_i = 0, sysclk_is_osc_i = 0, power_managed_i = 0, sev = 0, uo = 0, go = 0, done;
    logic ext_clock_pin_i, osc_clock_i, osc_run_o, osc_in_pin_oe_o, osc_out_pin_oe_o, pins_read_zero_o;
    logic [7:0] ctl = 0, b = 0;
    logic [15:0] cnt = 0, v, got;
    int fails = 0, n_tests = 0, ticks = 0, i, k;
    sbtc_timer i_dut (.*);
    sbtc_clk_src i_src (.clk_i(clk_i), .use_osc_i(uo), .go_i(go), .ext_o(ext_clock_pin_i),
        .osc_o(osc_clock_i), .done_o(done));
    always #4 clk_i = ~clk_i;
    // hang guard
    always @(posedge clk_i) begin
        ticks++;
        if (ticks > 20000) begin
            fails++;
            results();
        end
    end
    task automatic results();
        $display("checks %0d mismatches %0d", n_tests, fails);
        if (fails == 0 && n_tests > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask : results
    task automatic chk(input logic [31:0] s, input logic [31:0] e);
        n_tests++;
        if (s !== e) begin
            fails++;
            $display("wrong value at %0t: %h not %h", $time, s, e);
        end
    endtask : chk
    // classic cycle; trigger pulse lands on the request edge when sev is set
    task automatic wb(input logic we, input logic [4:0] a, input logic [7:0] d);
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i <= we;
        wb_adr_i <= a;
        wb_sel_i <= 4'h1;
        wb_dat_i <= {24'h0, d};
        // trigger shares the taking edge with the request so it truly coincides
        special_event_i <= sev;
        @(posedge clk_i);
        special_event_i <= 1'b0;
        while (wb_ack_o !== 1'b1) @(posedge clk_i);
        q = wb_dat_o;
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
        @(posedge clk_i);
    endtask : wb
    // write with count model update
    task automatic wr(input logic [4:0] a, input logic [7:0] d);
        wb(1'b1, a, d);
        if (a == 5'h00) ctl = d & 8'hBF;
        if (a == 5'h08 && ctl[7]) b = d;
        if (a == 5'h08 && !ctl[7]) cnt[15:8] = d;
        if (a == 5'h04) cnt = {ctl[7] ? b : cnt[15:8], d};
    endtask : wr
    task automatic rdc(input logic [4:0] a, input logic [31:0] e);
        wb(1'b0, a, 8'h00);
        chk(q, e);
    endtask : rdc
    task automatic rc();
        wb(1'b0, 5'h04, 8'h00);
        got[7:0] = q[7:0];
        wb(1'b0, 5'h08, 8'h00);
        got[15:8] = q[7:0];
    endtask : rc
    task automatic hold(ref logic s);
        k = 0;
        while (s !== 1'b1 && k < 400) begin
            @(posedge clk_i);
            k++;
        end
    endtask : hold
    task automatic zero();
        wr(5'h00, 8'h80);
        wr(5'h08, 8'h00);
        wr(5'h04, 8'h00);
    endtask : zero
    initial begin
        void'($urandom(78));
        repeat (2) @(posedge clk_i);
        rst_i <= 1'b0;
        power_managed_i <= 1'b1;
        rdc(5'h00, 32'h0);
        rdc(5'h14, 32'h0);
        sysclk_is_osc_i <= 1'b1;
        wr(5'h00, 8'h40);
        rdc(5'h00, 32'h40);
        sysclk_is_osc_i <= 1'b0;
        rdc(5'h00, 32'h0);
        // buffered access with random counts
        for (i = 0; i < 3; i++) begin
            v = 16'($urandom);
            wr(5'h00, 8'h80);
            wr(5'h08, v[15:8]);
            wr(5'h04, v[7:0]);
            wr(5'h08, ~v[15:8]);
            rdc(5'h04, {24'h0, cnt[7:0]});
            rdc(5'h08, {24'h0, cnt[15:8]});
        end
        wr(5'h00, 8'h00);
        wr(5'h08, 8'h5A);
        rdc(5'h08, 32'h5A);
        rdc(5'h04, {24'h0, cnt[7:0]});
        // write beats trigger, then trigger clears without flag
        wr(5'h00, 8'h80);
        wr(5'h08, 8'h12);
        sev = 1'b1;
        wr(5'h04, 8'h77);
        sev = 1'b0;
        rc();
        chk({16'h0, got}, {16'h0, cnt});
        sev = 1'b1;
        rdc(5'h00, 32'h80);
        sev = 1'b0;
        rc();
        chk({16'h0, got}, 32'h0);
        rdc(5'h0C, 32'h0);
        // prescale ratios, bypass bit set but ignored on internal clock
        for (i = 0; i < 4; i++) begin
            zero();
            wr(5'h00, 8'h85 | 8'(i << 4));
            repeat (256) @(posedge clk_i);
            wr(5'h00, 8'h80);
            rc();
            chk({31'h0, (got - 16'(64 >> i)) <= 16'h1}, 32'h1);
            repeat (20) @(posedge clk_i);
            rdc(5'h04, {24'h0, got[7:0]});
        end
        // wrap sets sticky flag; mask gates irq; read clears
        wr(5'h08, 8'hFF);
        wr(5'h04, 8'hF0);
        wr(5'h10, 8'h01);
        wr(5'h00, 8'h81);
        hold(irq_o);
        wr(5'h00, 8'h80);
        chk({31'h0, irq_o}, 32'h1);
        wr(5'h10, 8'h00);
        chk({31'h0, irq_o}, 32'h0);
        wr(5'h10, 8'h01);
        chk({31'h0, irq_o}, 32'h1);
        rdc(5'h0C, 32'h1);
        rdc(5'h0C, 32'h0);
        rc();
        chk({31'h0, got < 16'h40}, 32'h1);
        // sync, async and crystal counting of five pulses
        for (i = 0; i < 3; i++) begin
            zero();
            wr(5'h00, i == 0 ? 8'h83 : i == 1 ? 8'h87 : 8'h8B);
            uo <= (i == 2);
            go <= 1'b1;
            @(posedge clk_i);
            go <= 1'b0;
            repeat (2) @(posedge clk_i);
            hold(done);
            chk({31'h0, osc_run_o}, {31'h0, 1'(i == 2)});
            wr(5'h00, 8'h80);
            rc();
            chk({16'h0, got}, 32'h5);
        end
        results();
    end
endmodule : tb_top
`default_nettype wire
